// [hw/csl_lock.sv]
// Code security lock: holds the sampled lock bits and gates accesses.
// Assumes lock byte is presented on I_LOCK_BYTE, stable during reset exit.
`timescale 1ns/1ps
module csl_lock
  import csl_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [7:0] I_LOCK_BYTE,
  input csl_req_t I_REQ,
  input wire logic [1:0] I_SIG_INDEX,
  input wire logic I_SIG_READ,
  input wire logic [15:0] I_IMG_ADDR,
  output csl_gnt_t O_GNT,
  output logic O_EXEC_FAULT,
  output logic O_LOCK_VALID,
  output logic [1:0] O_LEVEL,
  output logic O_LOCK_UNDEFINED,
  output logic [7:0] O_SIG_DATA,
  output logic O_SIG_VALID,
  output logic O_IMG_IN_RANGE
);

  // ==========================================================
  // Lock byte sampling
  // Caught one clock after reset release, never inside the async reset.
  logic [7:0] lock_byte_q, lock_byte_d;
  logic sampled_q, sampled_d;

  always_comb begin
    lock_byte_d = lock_byte_q;
    sampled_d = 1'b1;
    if (!sampled_q) begin
      lock_byte_d = I_LOCK_BYTE;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lock_byte_q <= CSL_LOCK_BYTE_RST;
      sampled_q <= 1'b0;
    end else begin
      lock_byte_q <= lock_byte_d;
      sampled_q <= sampled_d;
    end
  end

  // Zero in the image means the protection is on
  logic lock_bit_one, lock_bit_two, lock_bit_three;
  assign lock_bit_one = !lock_byte_q[CSL_BIT_ONE_POS];
  assign lock_bit_two = !lock_byte_q[CSL_BIT_TWO_POS];
  assign lock_bit_three = !lock_byte_q[CSL_BIT_THREE_POS];

  csl_level_t level;
  logic undefined;

  csl_decode u_csl_decode (
    .i_bit_one(lock_bit_one),
    .i_bit_two(lock_bit_two),
    .i_bit_three(lock_bit_three),
    .o_level(level),
    .o_undefined(undefined)
  );

  // ==========================================================
  // Access gating
  // Until sampled everything but table reads without exec_external is refused: the worst case is assumed.
  csl_gnt_t gnt_q, gnt_d;
  logic fault_q, fault_d;
  logic lvl1, lvl2, lvl3;

  assign lvl1 = !sampled_q || (level != CSL_LVL_OPEN);
  assign lvl2 = !sampled_q || (level == CSL_LVL_TWO) ||
                (level == CSL_LVL_THREE);
  assign lvl3 = !sampled_q || (level == CSL_LVL_THREE);

  always_comb begin
    gnt_d.code_table_read = I_REQ.code_table_read &&
      !(lvl1 && I_REQ.exec_external);
    gnt_d.prog_write = I_REQ.prog_write && !lvl1;
    gnt_d.verify = I_REQ.verify && !lvl2;
    gnt_d.ext_fetch = I_REQ.ext_fetch && !lvl3;
    gnt_d.ram_access = I_REQ.ram_access && !lvl3;
    fault_d = I_REQ.ext_fetch && lvl3 && sampled_q;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gnt_q <= '0;
      fault_q <= 1'b0;
    end else begin
      gnt_q <= gnt_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================
  // Signature read and image range
  logic [7:0] sig_q, sig_d;
  logic sig_v_q, sig_v_d;
  logic img_q, img_d;

  always_comb begin
    sig_v_d = I_SIG_READ;
    sig_d = sig_q;
    if (I_SIG_READ) begin
      if (I_SIG_INDEX == 2'd0) begin
        sig_d = CSL_SIG_BYTE0;
      end else if (I_SIG_INDEX == 2'd1) begin
        sig_d = CSL_SIG_BYTE1;
      end else if (I_SIG_INDEX == 2'd2) begin
        sig_d = CSL_SIG_BYTE2;
      end else begin
        sig_d = CSL_SIG_NONE;
      end
    end
    img_d = (I_IMG_ADDR <= CSL_USER_LAST_ADDR);
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sig_q <= CSL_SIG_NONE;
      sig_v_q <= 1'b0;
      img_q <= 1'b0;
    end else begin
      sig_q <= sig_d;
      sig_v_q <= sig_v_d;
      img_q <= img_d;
    end
  end

  assign O_GNT = gnt_q;
  assign O_EXEC_FAULT = fault_q;
  assign O_LOCK_VALID = sampled_q;
  assign O_LEVEL = level;
  assign O_LOCK_UNDEFINED = undefined && sampled_q;
  assign O_SIG_DATA = sig_q;
  assign O_SIG_VALID = sig_v_q;
  assign O_IMG_IN_RANGE = img_q;

  // ==========================================================
  // Checks
  // One clock domain, so a default clock and reset keep the
  // property lines short; nothing is judged while reset is low.
  default clocking @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);

  // Refusals, seen one edge after the request is taken; level nesting checked in the same cycle
  no_prog_locked_a: assert property (
    lvl1 |=> !O_GNT.prog_write)
    else $error("program granted while locked");
  table_read_a: assert property (
    (lvl1 && I_REQ.exec_external) |=> !O_GNT.code_table_read)
    else $error("external table read granted");
  verify_block_a: assert property (
    lvl2 |=> !O_GNT.verify)
    else $error("verify granted at level two");
  ext_exec_a: assert property (
    (sampled_q && lvl3 && I_REQ.ext_fetch) |=>
    (O_EXEC_FAULT && !O_GNT.ext_fetch))
    else $error("external fetch not blocked");
  ram_block_a: assert property (
    lvl3 |=> !O_GNT.ram_access)
    else $error("ram granted at top level");
  cumulative_level_a: assert property (
    lvl3 |-> (lvl1 && lvl2))
    else $error("protection levels not cumulative");
  unsampled_deny_a: assert property (
    !sampled_q |=> (O_GNT == '0))
    else $error("grant before lock sampled");

  // Grants below levels one and three, so a stuck refusal is caught as well
  open_verify_a: assert property (
    (sampled_q && !lvl1 && I_REQ.verify) |=> O_GNT.verify)
    else $error("verify refused while open");
  open_prog_a: assert property (
    (sampled_q && !lvl1 && I_REQ.prog_write) |=> O_GNT.prog_write)
    else $error("program refused while open");
  low_fetch_a: assert property (
    (sampled_q && !lvl3 && I_REQ.ext_fetch) |=>
    (O_GNT.ext_fetch && !O_EXEC_FAULT))
    else $error("external fetch refused below top level");
  low_ram_a: assert property (
    (sampled_q && !lvl3 && I_REQ.ram_access) |=> O_GNT.ram_access)
    else $error("ram refused below top level");

  // Signature bytes, first and last of the three
  sig_read_a: assert property (
    (I_SIG_READ && I_SIG_INDEX == 2'd0) |=>
    (O_SIG_VALID && O_SIG_DATA == CSL_SIG_BYTE0))
    else $error("signature byte wrong");
  sig_last_a: assert property (
    (I_SIG_READ && I_SIG_INDEX == 2'd2) |=>
    (O_SIG_VALID && O_SIG_DATA == CSL_SIG_BYTE2))
    else $error("last signature byte wrong");

  // Lock byte held once sampled, and erased bits mean no protection
  sample_once_a: assert property (
    O_LOCK_VALID |=> (O_LOCK_VALID && $stable(lock_byte_q)))
    else $error("lock byte changed after sampling");
  lock_pos_a: assert property (
    (sampled_q && lock_byte_q[CSL_BIT_ONE_POS] &&
    lock_byte_q[CSL_BIT_TWO_POS] && lock_byte_q[CSL_BIT_THREE_POS])
    |-> level == CSL_LVL_OPEN)
    else $error("erased bits not open");

  // Main scenarios: every level reached, and a refused fetch
  open_c: cover property (sampled_q && level == CSL_LVL_OPEN);
  lvl1_c: cover property (sampled_q && level == CSL_LVL_ONE);
  lvl2_c: cover property (sampled_q && level == CSL_LVL_TWO);
  lvl3_c: cover property (O_EXEC_FAULT);

endmodule

// [hw/csl_pkg.sv]
// Package for the code security lock: lock byte layout, levels, carriers.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package csl_pkg;

  // ==========================================================
  // Lock byte layout in the ROM image
  localparam logic [15:0] CSL_LOCK_BYTE_ADDR = 16'h8020;
  localparam logic [15:0] CSL_USER_LAST_ADDR = 16'h7FFF;
  localparam int CSL_BIT_ONE_POS = 0;
  localparam int CSL_BIT_TWO_POS = 1;
  localparam int CSL_BIT_THREE_POS = 3;
  localparam logic [7:0] CSL_LOCK_BYTE_RST = 8'h00;

  // ==========================================================
  // Signature bytes (values arbitrary, neutral)
  localparam int CSL_SIG_COUNT = 3;
  localparam logic [7:0] CSL_SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] CSL_SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] CSL_SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] CSL_SIG_NONE = 8'h00;

  // ==========================================================
  // Protection levels
  typedef enum logic [1:0] {
    CSL_LVL_OPEN,
    CSL_LVL_ONE,
    CSL_LVL_TWO,
    CSL_LVL_THREE
  } csl_level_t;

  // Request group from core and programmer
  typedef struct packed {
    logic code_table_read;
    logic exec_external;
    logic ext_fetch;
    logic verify;
    logic prog_write;
    logic ram_access;
  } csl_req_t;

  // Grant group back to core and programmer
  typedef struct packed {
    logic code_table_read;
    logic ext_fetch;
    logic verify;
    logic prog_write;
    logic ram_access;
  } csl_gnt_t;

endpackage

// [hw/csl_decode.sv]
// Decoder from the three lock bits to a protection level.
// Assumes the lock bits are already in the enabled-is-true sense.
`timescale 1ns/1ps
module csl_decode
  import csl_pkg::*;
(
  input wire logic i_bit_one,
  input wire logic i_bit_two,
  input wire logic i_bit_three,
  output csl_level_t o_level,
  output logic o_undefined
);

  // ==========================================================
  // Cumulative decode
  // Odd combinations fall to the strongest level implied by any set bit,
  // so an illegal pattern never weakens protection.
  always_comb begin
    o_undefined = 1'b0;
    if (i_bit_three) begin
      o_level = CSL_LVL_THREE;
      o_undefined = !(i_bit_one && i_bit_two);
    end else if (i_bit_two) begin
      o_level = CSL_LVL_TWO;
      o_undefined = !i_bit_one;
    end else if (i_bit_one) begin
      o_level = CSL_LVL_ONE;
    end else begin
      o_level = CSL_LVL_OPEN;
    end
  end

endmodule

// [tb/csl_far_model.sv]
// Far-side model: the programming system that fixes the lock byte.
// Assumes the bench holds reset while the chosen level changes.
`timescale 1ns/1ps
module csl_far_model
  import csl_pkg::*;
(
  input wire logic [1:0] i_level,
  output logic [7:0] o_lock_byte
);
  // ==========================================================
  // Lock byte image
  // Only cumulative patterns are ever burnt; spare bits stay erased (1)
  always_comb begin
    o_lock_byte = 8'hFF;
    if (i_level >= 2'h1) begin
      o_lock_byte[CSL_BIT_ONE_POS] = 1'b0;
    end
    if (i_level >= 2'h2) begin
      o_lock_byte[CSL_BIT_TWO_POS] = 1'b0;
    end
    if (i_level == 2'h3) begin
      o_lock_byte[CSL_BIT_THREE_POS] = 1'b0;
    end
  end
endmodule

// [tb/code_security_lock_bench.sv]
// Bench for the code security lock: random requests at every level.
// Assumes the far-side model supplies only cumulative lock patterns.
`timescale 1ns/1ps
module code_security_lock_bench;
  import csl_pkg::*;
  typedef struct {int cyc; logic [7:0] e; logic [7:0] sd;} csl_note_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sig_rd = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] sidx = 2'h0;
  logic [15:0] addr = 16'h0000;
  csl_req_t req = '0;
  logic [7:0] lock, sdata;
  csl_gnt_t gnt;
  logic fault, valid, undef, sv, inr;
  logic [1:0] level_o;
  logic [31:0] rs = 32'h0000_a43e;
  logic [7:0] sig_tbl [4];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  csl_note_t q[$];
  csl_note_t n, m;

  // ==========================================================
  // Clock, design and far side
  always #5 clk = ~clk;
  always @(posedge clk) cyc++;
  csl_far_model u_csl_far_model(.i_level(lvl), .o_lock_byte(lock));
  csl_lock u_csl_lock(.I_REF_CLK(clk), .I_RST_B(rst_b), .I_LOCK_BYTE(lock),
    .I_REQ(req), .I_SIG_INDEX(sidx), .I_SIG_READ(sig_rd), .I_IMG_ADDR(addr),
    .O_GNT(gnt), .O_EXEC_FAULT(fault), .O_LOCK_VALID(valid),
    .O_LEVEL(level_o), .O_LOCK_UNDEFINED(undef), .O_SIG_DATA(sdata),
    .O_SIG_VALID(sv), .O_IMG_IN_RANGE(inr));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watcher: answers land one edge after the request was taken
  always @(posedge clk) begin
    #2;
    while (q.size() > 0 && q[0].cyc < cyc) begin
      n = q.pop_front();
      check({gnt, fault, sv, inr}, n.e);
      if (n.e[1]) check(sdata, n.sd);
    end
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #50000;
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // Driver: one reset per level, since the lock is sampled only once
  initial begin
    sig_tbl = '{CSL_SIG_BYTE0, CSL_SIG_BYTE1, CSL_SIG_BYTE2, CSL_SIG_NONE};
    for (int l = 0; l < 4; l++) begin
      #1;
      rst_b = 1'b0;
      lvl = l[1:0];
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({6'h00, undef, valid}, 8'h01);
      check({6'h00, level_o}, {6'h00, l[1:0]});
      repeat (40) begin
        @(posedge clk);
        #1;
        rs = xs(rs);
        req = csl_req_t'(rs[5:0]);
        sig_rd = rs[6];
        sidx = rs[8:7];
        // Half the addresses sit on the 7FFF/8000 edge of the user area
        addr = rs[9] ? 16'h7FFF + {15'h0000, rs[10]} : rs[31:16];
        m.cyc = cyc;
        m.sd = sig_tbl[sidx];
        m.e = {req.code_table_read && !(req.exec_external && l >= 1),
          req.ext_fetch && l < 3, req.verify && l < 2,
          req.prog_write && l == 0, req.ram_access && l < 3,
          req.ext_fetch && l == 3, sig_rd, addr <= 16'h7FFF};
        q.push_back(m);
      end
      @(posedge clk);
      #1;
      req = '0;
      sig_rd = 1'b0;
      repeat (2) @(posedge clk);
    end
    end_sim();
  end
endmodule
